//--- common/scl_pkg.sv
// Summary of operation
// - line 12-15 select at 0x14, word access
// - four 4-bit select fields, lines 15..12
// - low bits 000/001/010 pick ports A/B/C
// - fault register at 0x18, bits 8,2,1,0
// - hardware sets flag on parity error
// - writing one clears the parity flag
// - lock bits set by software, sticky
// - low-voltage lock routes detector to break
// - low-voltage lock freezes detector config fields
// - parity lock routes parity error to break
// - stall lock routes core stall to break
// - compensation register at 0x20, bits 8,0
// - bit 0 powers compensation cell up/down
// - bit 8 shows cell ready, read-only
package scl_pkg;

    // ------------------------------------------------------------
    // register offsets and reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  SCL_OFF_SRC   = 8'h14;
    localparam logic [7:0]  SCL_OFF_FAULT = 8'h18;
    localparam logic [7:0]  SCL_OFF_COMP  = 8'h20;
    localparam logic [15:0] SCL_RST_SRC   = 16'h0000;
    localparam logic [2:0]  SCL_RST_LOCK  = 3'h0;
    localparam logic        SCL_RST_BIT   = 1'h0;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int SCL_FLAG_BIT  = 8;
    localparam int SCL_LVD_BIT   = 2;
    localparam int SCL_PAR_BIT   = 1;
    localparam int SCL_STALL_BIT = 0;
    localparam int SCL_EN_BIT    = 0;
    localparam int SCL_RDY_BIT   = 8;
    localparam int SCL_SEL_W     = 4;
    localparam int SCL_LINES     = 4;
    localparam int SCL_SRC_W     = 16;

    // ------------------------------------------------------------
    // select codes and bus encodings
    // ------------------------------------------------------------
    localparam logic [2:0] SCL_SEL_PA   = 3'h0;
    localparam logic [2:0] SCL_SEL_PB   = 3'h1;
    localparam logic [2:0] SCL_SEL_PC   = 3'h2;
    localparam logic [2:0] SCL_HSIZE_W  = 3'h2;
    localparam logic       SCL_RESP_OK  = 1'h0;

endpackage : scl_pkg

//--- common/scl_fault_if.sv
`timescale 1ns/1ps
// fault register handshake between bus slave and routing logic
interface scl_fault_if;
    logic       ce;
    logic       wr;
    logic       clr;
    logic [2:0] set;
    logic       flag;
    logic [2:0] lock;
    logic       flag_nx;
    logic [2:0] lock_nx;
    logic       brk;
    modport ctl (output ce, wr, clr, set, input flag, lock, flag_nx, lock_nx, brk);
    modport rt  (input ce, wr, clr, set, output flag, lock, flag_nx, lock_nx, brk);
endinterface : scl_fault_if

//--- design/scl_fault_route.sv
`timescale 1ns/1ps
module scl_fault_route (
    input  logic    hclk,
    input  logic    hresetn,
    scl_fault_if.rt fi,
    input  logic    ram_parity_err,
    input  logic    low_volt_irq,
    input  logic    core_stall_output
);
    typedef struct packed {
        logic       flag;
        logic [2:0] lock;
        logic       brk;
    } scl_rt_st_t;

    scl_rt_st_t q;
    scl_rt_st_t d;

    // next state: flag, sticky locks, gated break
    always_comb begin
        d      = q;
        d.flag = ram_parity_err | (q.flag & ~(fi.wr & fi.clr));
        d.lock = q.lock | (fi.wr ? fi.set : 3'h0);
        d.brk  = (q.lock[scl_pkg::SCL_LVD_BIT] & low_volt_irq)
               | (q.lock[scl_pkg::SCL_PAR_BIT] & ram_parity_err)
               | (q.lock[scl_pkg::SCL_STALL_BIT] & core_stall_output);
    end

    // state register, frozen while ce is low
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '{scl_pkg::SCL_RST_BIT, scl_pkg::SCL_RST_LOCK, 1'h0};
        end else if (fi.ce) begin
            q <= d;
        end
    end

    assign fi.flag    = q.flag;
    assign fi.lock    = q.lock;
    assign fi.flag_nx = d.flag;
    assign fi.lock_nx = d.lock;
    assign fi.brk     = q.brk;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    flag_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
        fi.ce && ram_parity_err |=> q.flag) else $error("parity flag not set");
    flag_win_a: assert property (@(posedge hclk) disable iff (!hresetn)
        fi.ce && fi.wr && fi.clr && ram_parity_err |=> q.flag) else $error("error lost on clear");
    flag_clr_a: assert property (@(posedge hclk) disable iff (!hresetn)
        fi.ce && fi.wr && fi.clr && !ram_parity_err |=> !q.flag) else $error("flag not cleared");
    flag_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
        fi.ce && fi.wr && !fi.clr && q.flag |=> q.flag) else $error("flag lost on zero write");
    lock_sticky_a: assert property (@(posedge hclk) disable iff (!hresetn)
        1'b1 |=> ($past(q.lock) & ~q.lock) == 3'h0) else $error("lock bit dropped");
    lock_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
        fi.ce && fi.wr |=> (q.lock & $past(fi.set)) == $past(fi.set)) else $error("lock not set");
    brk_open_a: assert property (@(posedge hclk) disable iff (!hresetn)
        fi.ce && q.lock == 3'h0 |=> !q.brk) else $error("break while unlocked");
    brk_lvd_a: assert property (@(posedge hclk) disable iff (!hresetn)
        fi.ce && q.lock[2] && low_volt_irq |=> q.brk) else $error("detector not routed");
    brk_par_a: assert property (@(posedge hclk) disable iff (!hresetn)
        fi.ce && q.lock[1] && ram_parity_err |=> q.brk) else $error("parity not routed");
    brk_stall_a: assert property (@(posedge hclk) disable iff (!hresetn)
        fi.ce && q.lock[0] && core_stall_output |=> q.brk) else $error("stall not routed");

endmodule : scl_fault_route

//--- design/scl_top.sv
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
module scl_top (
    input  logic        hclk,
    input  logic        hresetn,
    input  logic        ce,
    input  logic        hsel,
    input  logic [31:0] haddr,
    input  logic [1:0]  htrans,
    input  logic        hwrite,
    input  logic [2:0]  hsize,
    input  logic [31:0] hwdata,
    input  logic        hready,
    output logic        hreadyout,
    output logic        hresp,
    output logic [31:0] hrdata,
    input  logic [3:0]  line_pin_a,
    input  logic [3:0]  line_pin_b,
    input  logic [3:0]  line_pin_c,
    input  logic        ram_parity_err,
    input  logic        low_volt_irq,
    input  logic        core_stall_output,
    input  logic        comp_cell_ready,
    output logic [3:0]  external_interrupt_line,
    output logic        timer_break,
    output logic        low_volt_cfg_lock,
    output logic        comp_cell_enable
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic        wr_ph;
        logic [7:0]  wr_off;
        logic [15:0] src;
        logic        en;
        logic        rdy;
        logic [31:0] rdata;
        logic [3:0]  line;
        logic        rdyo;
        logic        resp;
    } scl_top_st_t;

    localparam scl_top_st_t SCL_ST_RST = '{
        wr_ph  : 1'h0,
        wr_off : 8'h00,
        src    : scl_pkg::SCL_RST_SRC,
        en     : scl_pkg::SCL_RST_BIT,
        rdy    : 1'h0,
        rdata  : 32'h0000_0000,
        line   : 4'h0,
        rdyo   : 1'h1,
        resp   : scl_pkg::SCL_RESP_OK
    };

    scl_top_st_t q;
    scl_top_st_t d;
    logic        acc;
    logic        rd_acc;
    logic        wr_acc;

    scl_fault_if fi ();

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------

    // offset match on a word-aligned low address
    function automatic logic scl_hit(input logic [7:0] off, input logic [7:0] reg_off);
        scl_hit = (off == reg_off);
    endfunction : scl_hit

    // pin chosen by one select field, reserved codes give zero
    function automatic logic scl_pick(input logic [3:0] sel, input logic pa, input logic pb,
                                      input logic pc);
        logic r;
        r = 1'b0;
        case (sel[2:0])
            scl_pkg::SCL_SEL_PA: r = pa;
            scl_pkg::SCL_SEL_PB: r = pb;
            scl_pkg::SCL_SEL_PC: r = pc;
            default:             r = 1'b0;
        endcase
        scl_pick = r;
    endfunction : scl_pick

    // read word assembled from next-state values
    function automatic logic [31:0] scl_read(input logic [7:0] off, input logic [15:0] src,
                                             input logic flag, input logic [2:0] lock,
                                             input logic en, input logic rdy);
        logic [31:0] w;
        w = 32'h0000_0000;
        if (scl_hit(off, scl_pkg::SCL_OFF_SRC)) begin
            w[scl_pkg::SCL_SRC_W-1:0] = src;
        end
        if (scl_hit(off, scl_pkg::SCL_OFF_FAULT)) begin
            w[scl_pkg::SCL_FLAG_BIT] = flag;
            w[2:0]                   = lock;
        end
        if (scl_hit(off, scl_pkg::SCL_OFF_COMP)) begin
            w[scl_pkg::SCL_RDY_BIT] = rdy;
            w[scl_pkg::SCL_EN_BIT]  = en;
        end
        scl_read = w;
    endfunction : scl_read

    // ------------------------------------------------------------
    // bus address phase
    // ------------------------------------------------------------

    // transfer accepted when selected, active and ready
    assign acc    = hsel && htrans[1] && hready;
    assign rd_acc = acc && !hwrite;
    assign wr_acc = acc && hwrite && (hsize == scl_pkg::SCL_HSIZE_W);

    // ------------------------------------------------------------
    // fault register link
    // ------------------------------------------------------------

    // write strobe and data for the routing logic
    assign fi.ce  = ce;
    assign fi.wr  = q.wr_ph && scl_hit(q.wr_off, scl_pkg::SCL_OFF_FAULT);
    assign fi.clr = hwdata[scl_pkg::SCL_FLAG_BIT];
    assign fi.set = hwdata[2:0];

    scl_fault_route u_route (
        .hclk              (hclk),
        .hresetn           (hresetn),
        .fi                (fi),
        .ram_parity_err    (ram_parity_err),
        .low_volt_irq      (low_volt_irq),
        .core_stall_output (core_stall_output)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------

    // data phase writes, pin muxing, read capture
    always_comb begin
        d = q;
        // write data phase, reserved bits dropped
        if (q.wr_ph && scl_hit(q.wr_off, scl_pkg::SCL_OFF_SRC)) begin
            d.src = hwdata[scl_pkg::SCL_SRC_W-1:0];
        end
        if (q.wr_ph && scl_hit(q.wr_off, scl_pkg::SCL_OFF_COMP)) begin
            d.en = hwdata[scl_pkg::SCL_EN_BIT];
        end
        // ready status follows the cell only
        d.rdy = comp_cell_ready;
        // address phase capture
        d.wr_ph  = wr_acc;
        d.wr_off = haddr[7:0];
        // one select field per line, line 12 lowest
        for (int i = 0; i < scl_pkg::SCL_LINES; i++) begin
            d.line[i] = scl_pick(q.src[i*scl_pkg::SCL_SEL_W +: scl_pkg::SCL_SEL_W],
                                 line_pin_a[i], line_pin_b[i], line_pin_c[i]);
        end
        // read data valid through the data phase
        if (rd_acc) begin
            d.rdata = scl_read(haddr[7:0], d.src, fi.flag_nx, fi.lock_nx, d.en, d.rdy);
        end
        d.rdyo = 1'b1;
        d.resp = scl_pkg::SCL_RESP_OK;
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------

    // all state held while ce is low
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= SCL_ST_RST;
        end else if (ce) begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------

    // every output from a flip-flop
    assign hreadyout               = q.rdyo;
    assign hresp                   = q.resp;
    assign hrdata                  = q.rdata;
    assign external_interrupt_line = q.line;
    assign comp_cell_enable        = q.en;
    assign timer_break             = fi.brk;
    assign low_volt_cfg_lock       = fi.lock[scl_pkg::SCL_LVD_BIT];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------

    // word write request at a given offset
    sequence s_wr(logic [7:0] off);
        ce && wr_acc && (haddr[7:0] == off);
    endsequence

    // read request at a given offset
    sequence s_rd(logic [7:0] off);
        ce && rd_acc && (haddr[7:0] == off);
    endsequence

    src_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        s_wr(scl_pkg::SCL_OFF_SRC) ##1 ce |=> q.src == $past(hwdata[15:0]))
        else $error("select write lost");

    narrow_wr_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && acc && hwrite && hsize != scl_pkg::SCL_HSIZE_W |=> !q.wr_ph)
        else $error("narrow write taken");

    okay_resp_a: assert property (@(posedge hclk) disable iff (!hresetn)
        1'b1 |-> hreadyout && hresp == scl_pkg::SCL_RESP_OK)
        else $error("bad bus response");

    line_mux_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && q.src[2:0] == scl_pkg::SCL_SEL_PB |=> external_interrupt_line[0] == $past(line_pin_b[0]))
        else $error("line 12 not from port B");

    line_top_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && q.src[14:12] == scl_pkg::SCL_SEL_PC |=> external_interrupt_line[3] == $past(line_pin_c[3]))
        else $error("line 15 not from port C");

    line_rsv_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && q.src[2:0] > scl_pkg::SCL_SEL_PC |=> !external_interrupt_line[0])
        else $error("reserved code drives line");

    src_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
        s_rd(scl_pkg::SCL_OFF_SRC) |=> hrdata == {16'h0000, q.src})
        else $error("select readback wrong");

    fault_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
        s_rd(scl_pkg::SCL_OFF_FAULT) |=> hrdata[31:9] == 23'h0 && hrdata[7:3] == 5'h0
        && hrdata[8] == fi.flag && hrdata[2:0] == fi.lock)
        else $error("fault readback wrong");

    comp_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
        s_rd(scl_pkg::SCL_OFF_COMP) |=> hrdata[31:9] == 23'h0 && hrdata[7:1] == 7'h0
        && hrdata[8] == q.rdy && hrdata[0] == q.en)
        else $error("compensation readback wrong");

    comp_en_a: assert property (@(posedge hclk) disable iff (!hresetn)
        s_wr(scl_pkg::SCL_OFF_COMP) ##1 ce |=> comp_cell_enable == $past(hwdata[0]))
        else $error("cell enable not written");

    rdy_ro_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && !comp_cell_ready) [*2] |-> !q.rdy)
        else $error("ready bit writable");

    low_volt_break_lock_a: assert property (@(posedge hclk) disable iff (!hresetn)
        s_wr(scl_pkg::SCL_OFF_FAULT) ##1 (ce && hwdata[2]) |=> ##1 low_volt_cfg_lock)
        else $error("detector config not locked");

    flag_clr_a: assert property (@(posedge hclk) disable iff (!hresetn)
        s_wr(scl_pkg::SCL_OFF_FAULT) ##1 (ce && hwdata[8] && !ram_parity_err)
        |=> s_rd(scl_pkg::SCL_OFF_FAULT) |=> !hrdata[8] || $past(ram_parity_err))
        else $error("flag readback after clear");

    // ------------------------------------------------------------
    // hold, status and routing checks
    // ------------------------------------------------------------

    // data phase of a word write at a given offset
    sequence s_wr_dp(logic [7:0] off);
        s_wr(off) ##1 ce;
    endsequence

    rdy_follow_a: assert property (@(posedge hclk) disable iff (!hresetn)
        hresetn && ce |=> q.rdy == $past(comp_cell_ready))
        else $error("ready status not tracking cell");

    comp_ro_wr_a: assert property (@(posedge hclk) disable iff (!hresetn)
        s_wr_dp(scl_pkg::SCL_OFF_COMP) |=> q.rdy == $past(comp_cell_ready))
        else $error("ready bit taken from write");

    en_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && !(q.wr_ph && q.wr_off == scl_pkg::SCL_OFF_COMP) |=> $stable(comp_cell_enable))
        else $error("cell enable moved without write");

    src_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && !(q.wr_ph && q.wr_off == scl_pkg::SCL_OFF_SRC) |=> $stable(q.src))
        else $error("select moved without write");

    rd_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && !rd_acc |=> $stable(hrdata))
        else $error("read data moved without read");

    unmapped_rd_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && rd_acc && haddr[7:0] != scl_pkg::SCL_OFF_SRC && haddr[7:0] != scl_pkg::SCL_OFF_FAULT
        && haddr[7:0] != scl_pkg::SCL_OFF_COMP |=> hrdata == 32'h0000_0000)
        else $error("unmapped offset reads nonzero");

    line_pa_a: assert property (@(posedge hclk) disable iff (!hresetn)
        hresetn && ce && q.src[2:0] == scl_pkg::SCL_SEL_PA |=> external_interrupt_line[0] == $past(line_pin_a[0]))
        else $error("line 12 not from port A");

    line_mid_a: assert property (@(posedge hclk) disable iff (!hresetn)
        hresetn && ce && q.src[6:4] == scl_pkg::SCL_SEL_PC |=> external_interrupt_line[1] == $past(line_pin_c[1]))
        else $error("line 13 not from port C");

    line_b14_a: assert property (@(posedge hclk) disable iff (!hresetn)
        hresetn && ce && q.src[10:8] == scl_pkg::SCL_SEL_PB |=> external_interrupt_line[2] == $past(line_pin_b[2]))
        else $error("line 14 not from port B");

    lock_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        s_wr_dp(scl_pkg::SCL_OFF_FAULT) |=> (fi.lock & $past(hwdata[2:0])) == $past(hwdata[2:0]))
        else $error("lock bit not set by write");

    lock_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
        s_wr_dp(scl_pkg::SCL_OFF_FAULT) |=> (fi.lock & $past(fi.lock)) == $past(fi.lock))
        else $error("lock bit cleared by write");

    cfg_lock_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        low_volt_cfg_lock |=> low_volt_cfg_lock)
        else $error("detector config unlocked");

    flag_wr_clr_a: assert property (@(posedge hclk) disable iff (!hresetn)
        s_wr_dp(scl_pkg::SCL_OFF_FAULT) ##0 (hwdata[8] && !ram_parity_err) |=> !fi.flag)
        else $error("flag survived clear");

    flag_keep_wr_a: assert property (@(posedge hclk) disable iff (!hresetn)
        s_wr_dp(scl_pkg::SCL_OFF_FAULT) ##0 (!hwdata[8] && fi.flag) |=> fi.flag)
        else $error("flag lost on zero write");

    flag_hw_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
        hresetn && ce && ram_parity_err |=> fi.flag)
        else $error("parity error not flagged");

    brk_idle_a: assert property (@(posedge hclk) disable iff (!hresetn)
        hresetn && ce && !low_volt_irq && !ram_parity_err && !core_stall_output |=> !timer_break)
        else $error("break without source");

    brk_lvd_top_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && low_volt_cfg_lock && low_volt_irq |=> timer_break)
        else $error("detector break missing");

    brk_par_top_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && fi.lock[1] && ram_parity_err |=> timer_break)
        else $error("parity break missing");

    brk_stall_top_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && fi.lock[0] && core_stall_output |=> timer_break)
        else $error("stall break missing");

endmodule : scl_top

//--- testbench/scl_top_tb.sv
`timescale 1ns/1ps
module scl_top_tb;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic        hclk;
    logic        hresetn;
    logic        ce;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic [3:0]  line_pin_a;
    logic [3:0]  line_pin_b;
    logic [3:0]  line_pin_c;
    logic        ram_parity_err;
    logic        low_volt_irq;
    logic        core_stall_output;
    logic        comp_cell_ready;
    logic [3:0]  external_interrupt_line;
    logic        timer_break;
    logic        low_volt_cfg_lock;
    logic        comp_cell_enable;
    int          n_fail;
    int          comparisons;
    logic        err_in_dp;
    logic [2:0]  lk;
    logic        fl;
    logic [31:0] v;
    logic [3:0]  e;

    localparam logic [7:0] SRC = scl_pkg::SCL_OFF_SRC;
    localparam logic [7:0] FLT = scl_pkg::SCL_OFF_FAULT;
    localparam logic [7:0] CMP = scl_pkg::SCL_OFF_COMP;

    // single slave: its ready is the bus ready
    assign hready = hreadyout;

    scl_top scl_top_i (
        .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .line_pin_a(line_pin_a), .line_pin_b(line_pin_b),
        .line_pin_c(line_pin_c), .ram_parity_err(ram_parity_err), .low_volt_irq(low_volt_irq),
        .core_stall_output(core_stall_output), .comp_cell_ready(comp_cell_ready),
        .external_interrupt_line(external_interrupt_line), .timer_break(timer_break),
        .low_volt_cfg_lock(low_volt_cfg_lock), .comp_cell_enable(comp_cell_enable)
    );

    // 100 MHz clock
    always #5 hclk = ~hclk;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic end_sim();
        if (n_fail == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // address phase then data phase; entered just after a rising edge
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [2:0] sz,
                        output logic [31:0] rdat);
        hsel   <= 1'h1;
        haddr  <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        hsize  <= sz;
        @(posedge hclk);
        while (hready !== 1'h1) @(posedge hclk);
        htrans         <= 2'h0;
        hwdata         <= d;
        ram_parity_err <= err_in_dp;
        @(posedge hclk);
        while (hready !== 1'h1) @(posedge hclk);
        rdat = hrdata;
        chk({31'h0, hresp}, {31'h0, scl_pkg::SCL_RESP_OK});
        if (err_in_dp) ram_parity_err <= 1'h0;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [2:0] sz = scl_pkg::SCL_HSIZE_W);
        logic [31:0] unused;
        xfer(a, 1'h1, d, sz, unused);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] got;
        xfer(a, 1'h0, 32'h0, scl_pkg::SCL_HSIZE_W, got);
        chk(got, exp);
    endtask : rd

    // hold break sources, then look at the shared break output
    task automatic brk(input logic lv, input logic par, input logic st, input logic exp);
        low_volt_irq      <= lv;
        ram_parity_err    <= par;
        core_stall_output <= st;
        repeat (3) @(posedge hclk);
        chk({31'h0, timer_break}, {31'h0, exp});
        low_volt_irq      <= 1'h0;
        ram_parity_err    <= 1'h0;
        core_stall_output <= 1'h0;
        @(posedge hclk);
    endtask : brk

    function automatic logic pick(input logic [2:0] code, input int i);
        case (code)
            scl_pkg::SCL_SEL_PA: return line_pin_a[i];
            scl_pkg::SCL_SEL_PB: return line_pin_b[i];
            scl_pkg::SCL_SEL_PC: return line_pin_c[i];
            default:             return 1'h0;
        endcase
    endfunction : pick

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        hclk = 0; hresetn = 0; ce = 1; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'h2; hwdata = 0;
        line_pin_a = 4'h5; line_pin_b = 4'h3; line_pin_c = 4'h9; ram_parity_err = 0; low_volt_irq = 0;
        core_stall_output = 0; comp_cell_ready = 0; n_fail = 0; comparisons = 0; err_in_dp = 0; lk = 0; fl = 0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'h1;
        // reset values of registers and outputs
        rd(SRC, 32'h0);
        rd(FLT, 32'h0);
        rd(CMP, 32'h0);
        chk({25'h0, external_interrupt_line, timer_break, low_volt_cfg_lock, comp_cell_enable},
            {25'h0, line_pin_a, 3'h0});
        // every legal select code on all four lines, top bit both ways
        for (int k = 0; k < 16; k++) begin
            if (k[2:0] > scl_pkg::SCL_SEL_PC) continue;
            v = {16'h0000, {4{k[3:0]}}};
            wr(SRC, v);
            rd(SRC, v);
            repeat (2) @(posedge hclk);
            for (int i = 0; i < 4; i++) e[i] = pick(k[2:0], i);
            chk({28'h0, external_interrupt_line}, {28'h0, e});
        end
        // mixed fields, then pins move under them
        wr(SRC, 32'h0000_8210);
        line_pin_a <= 4'ha;
        line_pin_b <= 4'hc;
        line_pin_c <= 4'h6;
        repeat (3) @(posedge hclk);
        chk({28'h0, external_interrupt_line},
            {28'h0, line_pin_a[3], line_pin_c[2], line_pin_b[1], line_pin_a[0]});
        wr(SRC, 32'h0000_1111, 3'h0);
        rd(SRC, 32'h0000_8210);
        wr(8'h1c, 32'h0000_0001);
        rd(8'h1c, 32'h0);
        // locks clear: nothing reaches the break
        brk(1'h1, 1'h1, 1'h1, 1'h0);
        rd(FLT, 32'h100);
        wr(FLT, 32'h0);
        rd(FLT, 32'h100);
        err_in_dp = 1'h1;
        wr(FLT, 32'h100);
        err_in_dp = 1'h0;
        rd(FLT, 32'h100);
        wr(FLT, 32'h100);
        rd(FLT, 32'h0);
        // locks one at a time, each sticky, routing checked per source
        for (int i = 0; i < 3; i++) begin
            wr(FLT, 32'h1 << i);
            wr(FLT, 32'h0);
            lk[i] = 1'h1;
            rd(FLT, {23'h0, fl, 5'h0, lk});
            chk({31'h0, low_volt_cfg_lock}, {31'h0, lk[2]});
            for (int j = 0; j < 3; j++) begin
                brk(j == 2, j == 1, j == 0, lk[j]);
                if (j == 1) fl = 1'h1;
            end
        end
        // only a reset drops the locks
        hresetn <= 1'h0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'h1;
        rd(FLT, 32'h0);
        chk({31'h0, low_volt_cfg_lock}, 32'h0);
        // compensation cell enable and ready status
        comp_cell_ready <= 1'h1;
        wr(CMP, 32'h1);
        @(posedge hclk);
        chk({31'h0, comp_cell_enable}, 32'h1);
        rd(CMP, 32'h101);
        wr(CMP, 32'h0);
        rd(CMP, 32'h100);
        chk({31'h0, comp_cell_enable}, 32'h0);
        comp_cell_ready <= 1'h0;
        wr(CMP, 32'h100);
        rd(CMP, 32'h0);
        // transfers lost while the clock enable is low
        ce <= 1'h0;
        wr(CMP, 32'h1);
        ce <= 1'h1;
        rd(CMP, 32'h0);
        end_sim();
    end

    // watchdog against a hung handshake
    initial begin
        repeat (5000) @(posedge hclk);
        n_fail++;
        end_sim();
    end

endmodule : scl_top_tb
